//--- ucr_fifo_ctrl.v
`default_nettype none
`include "ucr_map.vh"

// Behaviour
// - transmit fill count reads back live
// - receive fill count reads back live
// - transmit wide mode bit, resets zero
// - receive wide mode bit, resets zero
// - write one purges receive FIFO, self-clearing
// - auto-open purges when receiver enabled
// - auto-close purges when receiver disabled
// - wait full packet or three characters
// - CDC driver uses 63-byte packets
// - fast forward answers bulk-in immediately
// - CDC below 40960 baud sets fast
// - flow control at watermark, reset 0x1c2
// - driver select bit: 0 CDC, 1 custom
// - suspend pin levels from sleep register
// - suspend-use off keeps pins unchanged
module ucr_fifo_ctrl (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Register port
   input wire [9:0] reg_addr_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [15:0] reg_wdata_in,
   output reg [15:0] reg_rdata_out,
   output reg reg_rvalid_out,
   // FIFO status and events
   input wire [9:0] tx_count_in,
   input wire rx_push_in,
   input wire rx_pop_in,
   output reg rx_purge_out,
   // UART side controls
   input wire rx_enable_in,
   input wire flow_enable_in,
   input wire [23:0] baud_rate_in,
   input wire char_tick_in,
   output reg tx_wide_out,
   output reg rx_wide_out,
   output reg flow_assert_out,
   output reg custom_driver_out,
   // Bulk-in forwarding
   input wire bulk_in_req_in,
   output reg fwd_go_out,
   output reg [9:0] fwd_len_out,
   // Suspend pin control
   input wire suspended_in,
   input wire use_suspend_in,
   input wire [15:0] pin_level_in,
   output reg [15:0] pin_level_out
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Stored register fields
   reg tx_wide_q;
   reg rx_wide_q;
   reg auto_open_q;
   reg auto_close_q;
   reg fast_q;
   reg [9:0] watermark_q;
   reg custom_q;
   reg [15:0] sleep_pins_q;
   // Internal state and the next read word
   reg rx_en_last_q;
   reg req_pend_q;
   reg [15:0] rdata_d;

   // Decode and status nets
   wire [9:0] rx_count;
   wire timeout;
   wire wr_purge;
   wire auto_purge;
   wire purge;
   wire [9:0] max_pkt;
   wire ready_full;
   wire fwd_now;
   wire low_baud_cdc;

   // ---------------------------------------------------------------
   // Receive purge sources
   // ---------------------------------------------------------------
   // Auto purges compare the enable with its value one edge back
   // A flush write and an enable edge in one cycle give one purge
   // purge on command
   assign wr_purge = reg_wr_in && (reg_addr_in == `UCR_RX_PURGE_CONTROL_OFS)
                     && reg_wdata_in[`UCR_PURGE_NOW_BIT];
   assign auto_purge = (auto_open_q && rx_enable_in && !rx_en_last_q)
                       || (auto_close_q && !rx_enable_in && rx_en_last_q);
   assign purge = wr_purge || auto_purge;

   // Reset value 0 makes an enable held through reset count as an edge
   // Enable edge tracker; rx_enable_in is on this clock already
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_en_last_q <= 1'b0;
      end else begin
         rx_en_last_q <= rx_enable_in;
      end
   end

   // Pops come from the host side as bytes leave for USB
   // receive fill count
   ucr_rx_tally u_tally (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .push_in(rx_push_in),
      .pop_in(rx_pop_in),
      .purge_in(purge),
      .count_out(rx_count)
   );

   // Armed only while bytes wait, so an empty FIFO never times out
   // Expiry holds, so a late request still sees it
   // three character timeout
   ucr_char_timer u_timer (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .restart_in(rx_push_in || purge),
      .armed_in(rx_count != 10'h000),
      .char_tick_in(char_tick_in),
      .expired_out(timeout)
   );

   // ---------------------------------------------------------------
   // Bulk-in forwarding decision
   // ---------------------------------------------------------------
   // Full packet uses the driver's packet size, not the FIFO depth
   // packet size by driver: 64 custom, 63 CDC
   assign max_pkt = custom_q ? `UCR_MAX_PKT_NORMAL : `UCR_MAX_PKT_CDC;
   assign ready_full = (rx_count >= max_pkt);
   // Any one of three conditions releases a waiting request
   // fast forward
   assign fwd_now = (req_pend_q || bulk_in_req_in)
                    && (fast_q || ready_full || timeout);

   // Limitation: in fast mode an empty FIFO forwards a zero length
   // A request arriving while one is pending merges with it
   // Pending request held until data qualifies; one answer, then cleared
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_pend_q <= 1'b0;
         fwd_go_out <= 1'b0;
         fwd_len_out <= 10'h000;
      end else begin
         fwd_go_out <= fwd_now;
         if (fwd_now) begin
            req_pend_q <= 1'b0;
            fwd_len_out <= ready_full ? max_pkt : rx_count;
         end else if (bulk_in_req_in) begin
            req_pend_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Plain unsigned 24-bit compare against the baud limit
   // low baud under CDC
   assign low_baud_cdc = !custom_q && (baud_rate_in < `UCR_LOW_BAUD_BPS);

   // Purge register keeps its auto bits; bit 0 only makes a pulse
   // Trade-off: forced fast mode cannot be cleared below the baud limit
   // Writes store fields; reserved bits are dropped so they read zero
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_wide_q <= 1'b0;
         rx_wide_q <= 1'b0;
         auto_open_q <= `UCR_AUTO_OPEN_RST;
         auto_close_q <= `UCR_AUTO_CLOSE_RST;
         fast_q <= 1'b0;
         watermark_q <= `UCR_WATERMARK_RST;
         custom_q <= 1'b0;
         sleep_pins_q <= `UCR_SLEEP_PIN_RST;
      end else begin
         if (reg_wr_in) begin
            case (reg_addr_in)
               `UCR_TX_FRAMING_SELECT_OFS: begin
                  tx_wide_q <= reg_wdata_in[`UCR_WIDE_EN_BIT];
               end
               `UCR_RX_PURGE_CONTROL_OFS: begin
                  auto_open_q <= reg_wdata_in[`UCR_AUTO_OPEN_BIT];
                  auto_close_q <= reg_wdata_in[`UCR_AUTO_CLOSE_BIT];
               end
               `UCR_RX_FRAMING_SELECT_OFS: begin
                  rx_wide_q <= reg_wdata_in[`UCR_WIDE_EN_BIT];
               end
               `UCR_FAST_FORWARD_ENABLE_OFS: begin
                  fast_q <= reg_wdata_in[`UCR_FAST_EN_BIT];
               end
               // Watermark keeps only its ten count bits
               // watermark store
               `UCR_RX_FLOW_WATERMARK_OFS: begin
                  watermark_q <= reg_wdata_in[`UCR_COUNT_MSB:0];
               end
               `UCR_HOST_DRIVER_SELECT_OFS: begin
                  custom_q <= reg_wdata_in[`UCR_CUSTOM_BIT];
               end
               `UCR_SLEEP_PIN_LEVELS_OFS: begin
                  sleep_pins_q <= reg_wdata_in & `UCR_SLEEP_PIN_MASK;
               end
               default: begin
               end
            endcase
         end
         // automatic fast set, wins over a software clear
         if (low_baud_cdc) begin
            fast_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Count fields read with zeros in bits 15:10
   // Write-only and unmapped offsets read as zero
   always @* begin
      rdata_d = 16'h0000;
      case (reg_addr_in)
         `UCR_TX_FILL_LEVEL_OFS: rdata_d = {6'h00, tx_count_in};
         `UCR_TX_FRAMING_SELECT_OFS: rdata_d = {15'h0000, tx_wide_q};
         `UCR_RX_FILL_LEVEL_OFS: rdata_d = {6'h00, rx_count};
         `UCR_RX_FRAMING_SELECT_OFS: rdata_d = {15'h0000, rx_wide_q};
         `UCR_FAST_FORWARD_ENABLE_OFS: rdata_d = {15'h0000, fast_q};
         `UCR_RX_FLOW_WATERMARK_OFS: rdata_d = {6'h00, watermark_q};
         `UCR_SLEEP_PIN_LEVELS_OFS: rdata_d = sleep_pins_q;
         default: rdata_d = 16'h0000;
      endcase
   end

   // Read data holds between reads so the master may take it late
   // Read data registered; answer one cycle after the strobe
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs toward UART, FIFO and pads
   // ---------------------------------------------------------------
   // All outputs registered so the pad and UART paths see clean levels
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_purge_out <= 1'b0;
         tx_wide_out <= 1'b0;
         rx_wide_out <= 1'b0;
         flow_assert_out <= 1'b0;
         custom_driver_out <= 1'b0;
         pin_level_out <= 16'h0000;
      end else begin
         // FIFO sees the purge one edge after the edge that clears the count
         // one-cycle purge pulse
         rx_purge_out <= purge;
         // Framing selects lag the stored bits by one cycle
         // transmit framing
         tx_wide_out <= tx_wide_q;
         rx_wide_out <= rx_wide_q;
         // Compares the count before this edge's push
         // flow assert at watermark
         flow_assert_out <= flow_enable_in && (rx_count >= watermark_q);
         // Driver select mirrors the stored bit for the class logic
         custom_driver_out <= custom_q;
         // Pins outside the sleep mask always follow the normal level
         // suspend pin levels
         if (suspended_in && use_suspend_in) begin
            pin_level_out <= (pin_level_in & ~`UCR_SLEEP_PIN_MASK) | sleep_pins_q;
         end else begin
            pin_level_out <= pin_level_in;
         end
      end
   end

endmodule // ucr_fifo_ctrl
`default_nettype wire

//--- ucr_map.vh
`ifndef UCR_MAP_VH
`define UCR_MAP_VH

// ---------------------------------------------------------------
// Register offsets (word index on the register port)
// ---------------------------------------------------------------
`define UCR_TX_FILL_LEVEL_OFS 10'h041
`define UCR_TX_FRAMING_SELECT_OFS 10'h042
`define UCR_RX_PURGE_CONTROL_OFS 10'h043
`define UCR_RX_FILL_LEVEL_OFS 10'h044
`define UCR_RX_FRAMING_SELECT_OFS 10'h045
`define UCR_FAST_FORWARD_ENABLE_OFS 10'h046
`define UCR_RX_FLOW_WATERMARK_OFS 10'h047
`define UCR_HOST_DRIVER_SELECT_OFS 10'h060
`define UCR_SLEEP_PIN_LEVELS_OFS 10'h06a

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define UCR_WIDE_EN_BIT 0
`define UCR_PURGE_NOW_BIT 0
`define UCR_AUTO_OPEN_BIT 1
`define UCR_AUTO_CLOSE_BIT 2
`define UCR_FAST_EN_BIT 0
`define UCR_CUSTOM_BIT 0
`define UCR_COUNT_MSB 9
`define UCR_SLEEP_PIN_MASK 16'h3ccf

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define UCR_WATERMARK_RST 10'h1c2
`define UCR_AUTO_OPEN_RST 1'b1
`define UCR_AUTO_CLOSE_RST 1'b0
`define UCR_SLEEP_PIN_RST 16'h0000

// ---------------------------------------------------------------
// Counts and limits
// ---------------------------------------------------------------
`define UCR_FIFO_DEPTH 10'h200
`define UCR_MAX_PKT_NORMAL 10'h040
`define UCR_MAX_PKT_CDC 10'h03f
`define UCR_TIMEOUT_CHARS 2'h3
`define UCR_LOW_BAUD_BPS 24'h00a000

`endif

//--- ucr_rx_tally.v
`default_nettype none
`include "ucr_map.vh"

// Receive fill counter: push and pop move it, a purge drops it to zero
module ucr_rx_tally (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Events
   input wire push_in,
   input wire pop_in,
   input wire purge_in,
   // Level
   output reg [9:0] count_out
);

   wire full;
   wire empty;
   wire do_push;
   wire do_pop;

   assign full = (count_out == `UCR_FIFO_DEPTH);
   assign empty = (count_out == 10'h000);
   // A full FIFO drops new bytes, an empty one has nothing to pop
   assign do_push = push_in && !full;
   assign do_pop = pop_in && !empty;

   // Counter; a purge wins because bytes in flight belong to the old data
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_out <= 10'h000;
      end else if (purge_in) begin
         count_out <= 10'h000;
      end else if (do_push && !do_pop) begin
         count_out <= count_out + 10'h001;
      end else if (do_pop && !do_push) begin
         count_out <= count_out - 10'h001;
      end
   end

endmodule // ucr_rx_tally
`default_nettype wire

//--- ucr_char_timer.v
`default_nettype none
`include "ucr_map.vh"

// Counts character times of receive silence while data is waiting
module ucr_char_timer (
   // Clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // Control
   input wire restart_in,
   input wire armed_in,
   input wire char_tick_in,
   // Result
   output reg expired_out
);

   reg [1:0] chars_q;

   // Restart on every received byte; hold expiry until restarted or disarmed
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chars_q <= 2'h0;
         expired_out <= 1'b0;
      end else if (restart_in || !armed_in) begin
         chars_q <= 2'h0;
         expired_out <= 1'b0;
      end else if (char_tick_in && !expired_out) begin
         chars_q <= chars_q + 2'h1;
         expired_out <= (chars_q + 2'h1 == `UCR_TIMEOUT_CHARS);
      end
   end

endmodule // ucr_char_timer
`default_nettype wire

//--- ucr_fifo_ctrl_asserts.sv
`default_nettype none
module ucr_fifo_ctrl_chk (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [9:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_rvalid_out,
   // Receive and forwarding
   input wire logic rx_purge_out,
   input wire logic rx_enable_in,
   input wire logic flow_enable_in,
   input wire logic flow_assert_out,
   input wire logic [23:0] baud_rate_in,
   input wire logic bulk_in_req_in,
   input wire logic fwd_go_out,
   input wire logic tx_wide_out,
   input wire logic custom_driver_out,
   // Suspend pins
   input wire logic suspended_in,
   input wire logic use_suspend_in,
   input wire logic [15:0] pin_level_in,
   input wire logic [15:0] pin_level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_rd_ans; reg_rd_in |=> reg_rvalid_out; endproperty
   property p_no_ans; reg_rvalid_out |-> $past(reg_rd_in); endproperty
   property p_purge;
      reg_wr_in && reg_addr_in == 10'h043 && reg_wdata_in[0] |=> rx_purge_out;
   endproperty
   // Purge only from a flush write or a receiver enable edge
   property p_purge_why;
      rx_purge_out |-> $past(reg_wr_in && reg_addr_in == 10'h043)
         || $past(rx_enable_in) != $past(rx_enable_in, 2);
   endproperty
   property p_no_flow; !flow_enable_in |=> !flow_assert_out; endproperty
   // Forced fast bit is one cycle behind the driver bit and the baud
   property p_fast;
      !custom_driver_out && $past(rst_n_in) && $past(baud_rate_in) < 24'd40960
         && bulk_in_req_in |=> fwd_go_out;
   endproperty
   property p_pins_run;
      !(suspended_in && use_suspend_in) |=> pin_level_out == $past(pin_level_in);
   endproperty
   // Pins outside the sleep mask always pass straight through
   property p_pins_keep;
      suspended_in && use_suspend_in |=>
         ((pin_level_out ^ $past(pin_level_in)) & 16'hc330) == 16'h0000;
   endproperty
   // Registered outputs lag the write by two edges
   property p_wide; $changed(tx_wide_out) |-> $past(reg_wr_in && reg_addr_in == 10'h042, 2);
   endproperty
   property p_drv;
      $changed(custom_driver_out) |-> $past(reg_wr_in && reg_addr_in == 10'h060, 2);
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read gave no answer");
   a_no_ans: assert property (p_no_ans) else $error("answer without read");
   a_purge: assert property (p_purge) else $error("flush write missed");
   a_purge_why: assert property (p_purge_why) else $error("stray purge");
   a_no_flow: assert property (p_no_flow) else $error("flow while disabled");
   a_fast: assert property (p_fast) else $error("low baud not fast");
   a_pins_run: assert property (p_pins_run) else $error("pins not passed");
   a_pins_keep: assert property (p_pins_keep) else $error("unmasked pin moved");
   a_wide: assert property (p_wide) else $error("wide bit moved");
   a_drv: assert property (p_drv) else $error("driver bit moved");
   c_go: cover property (fwd_go_out);
   c_purge: cover property (rx_purge_out);
   c_flow: cover property (flow_assert_out);
endmodule // ucr_fifo_ctrl_chk

bind ucr_fifo_ctrl ucr_fifo_ctrl_chk u_chk (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
   .reg_rd_in, .reg_wdata_in, .reg_rvalid_out, .rx_purge_out, .rx_enable_in, .flow_enable_in,
   .flow_assert_out, .baud_rate_in, .bulk_in_req_in, .fwd_go_out, .tx_wide_out,
   .custom_driver_out, .suspended_in, .use_suspend_in, .pin_level_in, .pin_level_out);
`default_nettype wire

//--- ucr_host_model.sv
`default_nettype none
module ucr_host_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Bench control
   input wire logic ask_in,
   // Device side
   input wire logic fwd_go_in,
   input wire logic [9:0] fwd_len_in,
   output logic bulk_req_out,
   output logic [7:0] got_out,
   output logic [9:0] got_len_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Host polls once per ask and logs each forwarded packet length
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bulk_req_out <= 1'b0;
         got_out <= 8'h00;
         got_len_out <= 10'h000;
      end else begin
         bulk_req_out <= ask_in;
         got_out <= got_out + {7'h00, fwd_go_in};
         if (fwd_go_in) begin
            got_len_out <= fwd_len_in;
         end
      end
   end
endmodule // ucr_host_model
`default_nettype wire

//--- ucr_tb.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, rst_n_in, wr, rd, push, pop, rx_en, flow_en, tick, susp, use_s, ask;
   logic [9:0] addr, tx_cnt;
   logic [15:0] wdata, pin_in;
   logic [23:0] baud;
   logic [15:0] rdata, pin_out;
   logic rvalid, purge, txw, rxw, flow, cust, go, req;
   logic [9:0] len, got_len;
   logic [7:0] got;
   int err_total, samples_checked;
   logic [9:0] ofs [10] = '{10'h041, 10'h042, 10'h043, 10'h044, 10'h045, 10'h046, 10'h047,
      10'h060, 10'h06a, 10'h050};
   logic [15:0] rv [10] = '{16'h0155, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h01c2, 16'h0,
      16'h0, 16'h0};

   ucr_fifo_ctrl u_ucr_fifo_ctrl (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .tx_count_in(tx_cnt), .rx_push_in(push), .rx_pop_in(pop),
      .rx_purge_out(purge), .rx_enable_in(rx_en), .flow_enable_in(flow_en),
      .baud_rate_in(baud), .char_tick_in(tick), .tx_wide_out(txw), .rx_wide_out(rxw),
      .flow_assert_out(flow), .custom_driver_out(cust), .bulk_in_req_in(req),
      .fwd_go_out(go), .fwd_len_out(len), .suspended_in(susp), .use_suspend_in(use_s),
      .pin_level_in(pin_in), .pin_level_out(pin_out));
   ucr_host_model u_ucr_host_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ask_in(ask),
      .fwd_go_in(go), .fwd_len_in(len), .bulk_req_out(req), .got_out(got),
      .got_len_out(got_len));

   // ----------------------------------------
   // Clock and access tasks
   // ----------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   task cyc; @(posedge mclk_in); #1; endtask
   task print_verdict;
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Strobes drop for a whole cycle between two accesses
   task wrr(input logic [9:0] a, input logic [15:0] d);
      cyc; addr = a; wdata = d; wr = 1'b1; cyc; wr = 1'b0;
   endtask
   // Answer must arrive exactly one cycle after the read edge
   task rdc(input logic [9:0] a, input logic [15:0] e);
      cyc; addr = a; rd = 1'b1; cyc; rd = 1'b0;
      chk({15'h0, rvalid}, 16'h0001);
      chk(rdata, e);
   endtask
   task pushn(input int n); push = 1'b1; repeat (n) cyc; push = 1'b0; endtask
   // Slow case proves nothing leaves in the four cycles before the first character tick
   task fwd(input logic [9:0] e, input bit slow);
      logic [7:0] g;
      int i;
      g = got; ask = 1'b1; cyc; ask = 1'b0;
      if (slow) begin
         repeat (4) cyc;
         chk({8'h0, got}, {8'h0, g});
         repeat (3) begin tick = 1'b1; cyc; tick = 1'b0; cyc; end
      end
      for (i = 0; i < 20 && got == g; i++) cyc;
      if (got == g) begin chk({8'h0, got}, {8'h0, g + 8'h01}); print_verdict; end
      else chk({6'h0, got_len}, {6'h0, e});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      err_total = 0; samples_checked = 0;
      {wr, rd, push, pop, rx_en, flow_en, tick, susp, use_s, ask} = '0;
      addr = '0; wdata = '0; tx_cnt = 10'h155; pin_in = 16'ha5a5; baud = 24'd115200;
      rst_n_in = 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 rst_n_in = 1'b1;
      for (int i = 0; i < 10; i++) rdc(ofs[i], rv[i]);
      tx_cnt = 10'h200; rdc(10'h041, 16'h0200);
      wrr(10'h042, 16'h0001); rdc(10'h042, 16'h0001); chk({15'h0, txw}, 16'h1);
      wrr(10'h045, 16'h0001); rdc(10'h045, 16'h0001); chk({15'h0, rxw}, 16'h1);
      pushn(5); rdc(10'h044, 16'h0005);
      pop = 1'b1; cyc; pop = 1'b0; rdc(10'h044, 16'h0004);
      wrr(10'h043, 16'h0002); rdc(10'h044, 16'h0004);
      wrr(10'h043, 16'h0003); chk({15'h0, purge}, 16'h1);
      rdc(10'h044, 16'h0000);
      pushn(2); rx_en = 1'b1; cyc; cyc; rdc(10'h044, 16'h0000);
      wrr(10'h043, 16'h0004); pushn(3); rx_en = 1'b0; cyc; cyc;
      rdc(10'h044, 16'h0000);
      pushn(1); rx_en = 1'b1; cyc; cyc; rdc(10'h044, 16'h0001);
      wrr(10'h047, 16'h0004); flow_en = 1'b1; pushn(2); cyc;
      chk({15'h0, flow}, 16'h0);
      pushn(1); cyc; chk({15'h0, flow}, 16'h1);
      flow_en = 1'b0;
      wrr(10'h060, 16'h0001); cyc; chk({15'h0, cust}, 16'h1);
      wrr(10'h043, 16'h0005); pushn(10); fwd(10'd10, 1'b1);
      pushn(54); fwd(10'd64, 1'b0);
      wrr(10'h060, 16'h0000); fwd(10'd63, 1'b0);
      wrr(10'h043, 16'h0005); pushn(7); wrr(10'h046, 16'h0001); fwd(10'd7, 1'b0);
      wrr(10'h046, 16'h0000); baud = 24'd9600; cyc; rdc(10'h046, 16'h0001);
      fwd(10'd7, 1'b0);
      wrr(10'h06a, 16'h3ccf); rdc(10'h06a, 16'h3ccf);
      susp = 1'b1; use_s = 1'b1; cyc; chk(pin_out, 16'hbdef);
      wrr(10'h06a, 16'h0000); cyc; chk(pin_out, 16'h8120);
      use_s = 1'b0; cyc; chk(pin_out, 16'ha5a5);
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
